//--- rtl/prr_pkg.sv
package prr_pkg;
   // Register indices; byte address is four times the index
   localparam logic [5:0] IDX_START_LO = 6'h0C;
   localparam logic [5:0] IDX_START_MID = 6'h0D;
   localparam logic [5:0] IDX_START_TOP = 6'h0E;
   localparam logic [5:0] IDX_ROT_CTRL = 6'h1B;
   localparam logic [5:0] IDX_STRIDE = 6'h1C;
   // Rotation control fields
   localparam int unsigned CTL_EN_BIT = 7;
   localparam int unsigned CTL_ALT_BIT = 6;
   localparam int unsigned CTL_BOOST_BIT = 2;
   localparam int unsigned CTL_PCS_LSB = 0;
   localparam int unsigned CTL_PCS_W = 2;
   localparam logic [7:0] CTL_WMASK = 8'hC7;
   localparam logic [7:0] TOP_WMASK = 8'h01;
   // Reset values
   localparam logic [7:0] RST_START_LO = 8'h00;
   localparam logic [7:0] RST_START_MID = 8'h00;
   localparam logic [7:0] RST_START_TOP = 8'h00;
   localparam logic [7:0] RST_ROT_CTRL = 8'h00;
   localparam logic [7:0] RST_STRIDE = 8'h00;
   // Pixel divider
   localparam int unsigned DIV_SEL_W = 3;
   localparam int unsigned DIV_CNT_W = 4;
   localparam logic [DIV_SEL_W-1:0] DIV_SEL_MAX = 3'h4;
   // Refresh address width
   localparam int unsigned ADDR_W = 17;
endpackage

//--- rtl/prr_div_if.sv
`timescale 1ns/100ps
`default_nettype none
interface prr_div_if;
   import prr_pkg::*;
   logic [DIV_SEL_W-1:0] div_sel;
   logic pix_tick;
   modport ctl (output div_sel, input pix_tick);
   modport div (input div_sel, output pix_tick);
endinterface // prr_div_if
`default_nettype wire

//--- rtl/prr_pix_div.sv
`timescale 1ns/100ps
`default_nettype none
module prr_pix_div
   import prr_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   prr_div_if.div dv
);
   logic [DIV_CNT_W-1:0] cnt_q;
   logic [DIV_CNT_W-1:0] cnt_d;
   logic [DIV_CNT_W-1:0] limit;
   logic tick;

   if (DIV_SEL_MAX >= DIV_SEL_W'(DIV_CNT_W + 1)) begin : g_cnt_chk
      $error("divider counter too narrow");
   end

   // Divide the working clock by two to the power of div_sel
   always_comb begin
      limit = DIV_CNT_W'((1 << dv.div_sel) - 1);
      tick = (cnt_q >= limit);
      cnt_d = tick ? '0 : cnt_q + 1'b1;
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   assign dv.pix_tick = tick;
endmodule // prr_pix_div
`default_nettype wire

//--- rtl/prr_rotate.sv
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module prr_rotate
   import prr_pkg::*;
#(
   parameter int unsigned PANEL_W = 320,
   parameter int unsigned PANEL_H = 240
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic host_access_i,
   output logic mclk_fast_o,
   output logic screen2_en_o,
   output logic [ADDR_W-1:0] fetch_addr_o,
   output logic fetch_stb_o
);
   localparam int unsigned PIX_W = $clog2(PANEL_W);
   localparam int unsigned LIN_W = $clog2(PANEL_H);
   localparam logic [PIX_W-1:0] PIX_LAST = PIX_W'(PANEL_W - 1);
   localparam logic [LIN_W-1:0] LIN_LAST = LIN_W'(PANEL_H - 1);
   localparam logic [ADDR_W-1:0] LAND_LINE = ADDR_W'(PANEL_W);

   if (PANEL_W < 2 || PANEL_H < 2 || PANEL_W > 65536) begin : g_size_chk
      $error("panel size out of range");
   end

   prr_div_if div_if ();

   // Working clock is the input clock pin itself
   prr_pix_div u_div (
      .clk_i (clk_i),
      .rst_b_i (rst_b_i),
      .dv (div_if.div)
   );

   // ---------------- Register file ----------------
   logic [7:0] start_lo_q, start_lo_d;
   logic [7:0] start_mid_q, start_mid_d;
   logic [7:0] start_top_q, start_top_d;
   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] stride_q, stride_d;
   logic [31:0] prdata_q, prdata_d;
   logic idx_ok, hit, wr_en;
   logic [7:0] rd_byte;

   always_comb begin
      idx_ok = (paddr_i[1:0] == 2'h0);
      hit = idx_ok;
      rd_byte = 8'h00;
      unique case (paddr_i[7:2])
         IDX_START_LO: rd_byte = start_lo_q;
         IDX_START_MID: rd_byte = start_mid_q;
         IDX_START_TOP: rd_byte = start_top_q;
         IDX_ROT_CTRL: rd_byte = ctrl_q;
         IDX_STRIDE: rd_byte = stride_q;
         default: hit = 1'b0;
      endcase
      wr_en = psel_i && penable_i && pwrite_i && hit;
      start_lo_d = start_lo_q;
      start_mid_d = start_mid_q;
      start_top_d = start_top_q;
      ctrl_d = ctrl_q;
      stride_d = stride_q;
      if (wr_en) begin
         unique case (paddr_i[7:2])
            IDX_START_LO: start_lo_d = pwdata_i[7:0];
            IDX_START_MID: start_mid_d = pwdata_i[7:0];
            IDX_START_TOP: start_top_d = pwdata_i[7:0] & TOP_WMASK;
            IDX_ROT_CTRL: ctrl_d = pwdata_i[7:0] & CTL_WMASK;
            IDX_STRIDE: stride_d = pwdata_i[7:0];
            default: ;
         endcase
      end
      // Read data is captured in the setup cycle
      prdata_d = prdata_q;
      if (psel_i && !penable_i && !pwrite_i) begin
         prdata_d = hit ? {24'h000000, rd_byte} : 32'h00000000;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         start_lo_q <= RST_START_LO;
         start_mid_q <= RST_START_MID;
         start_top_q <= RST_START_TOP;
         ctrl_q <= RST_ROT_CTRL;
         stride_q <= RST_STRIDE;
         prdata_q <= 32'h00000000;
      end else begin
         start_lo_q <= start_lo_d;
         start_mid_q <= start_mid_d;
         start_top_q <= start_top_d;
         ctrl_q <= ctrl_d;
         stride_q <= stride_d;
         prdata_q <= prdata_d;
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && !hit;

   // ---------------- Mode decode ----------------
   logic portrait, alt, boost;
   logic [ADDR_W-1:0] start_raw, eff_start, stride_ext;
   logic [CTL_PCS_W-1:0] pcs;

   always_comb begin
      portrait = ctrl_q[CTL_EN_BIT];
      alt = portrait && ctrl_q[CTL_ALT_BIT];
      boost = portrait && ctrl_q[CTL_BOOST_BIT];
      pcs = ctrl_q[CTL_PCS_LSB +: CTL_PCS_W];
      start_raw = {start_top_q[0], start_mid_q, start_lo_q};
      stride_ext = {{(ADDR_W-8){1'b0}}, stride_q};
      if (!portrait) begin
         eff_start = {start_raw[15:0], 1'b0};
      end else if (alt) begin
         eff_start = start_raw;
      end else begin
         // Lowest row bit dropped: two-line granularity
         eff_start = start_raw & ~stride_ext;
      end
   end

   // Pixel divisor: select field in portrait, doubled again in alternate; landscape divides by one
   always_comb begin
      if (!portrait) begin
         div_if.div_sel = '0;
      end else begin
         div_if.div_sel = DIV_SEL_W'(pcs) + DIV_SEL_W'(alt);
      end
   end

   // Full-rate memory clock during host access when boosted
   assign mclk_fast_o = !portrait || (boost && host_access_i);
   assign screen2_en_o = !portrait;

   // ---------------- Refresh walker ----------------
   logic [PIX_W-1:0] pix_q, pix_d;
   logic [LIN_W-1:0] lin_q, lin_d;
   logic [ADDR_W-1:0] base_q, base_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic tick;

   assign tick = div_if.pix_tick;

   always_comb begin
      pix_d = pix_q;
      lin_d = lin_q;
      base_d = base_q;
      addr_d = addr_q;
      if (tick) begin
         if (pix_q != PIX_LAST) begin
            pix_d = pix_q + 1'b1;
            // Along a column in portrait, along a row in landscape
            addr_d = addr_q + (portrait ? stride_ext : 17'h00001);
         end else begin
            pix_d = '0;
            if (lin_q == LIN_LAST) begin
               lin_d = '0;
               base_d = eff_start;
            end else begin
               lin_d = lin_q + 1'b1;
               base_d = portrait ? base_q - 17'h00001 : base_q + LAND_LINE;
            end
            addr_d = base_d;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pix_q <= '0;
         lin_q <= '0;
         base_q <= '0;
         addr_q <= '0;
      end else begin
         pix_q <= pix_d;
         lin_q <= lin_d;
         base_q <= base_d;
         addr_q <= addr_d;
      end
   end

   assign fetch_addr_o = addr_q;
   assign fetch_stb_o = tick;

   // ---------------- Checks ----------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence s_alt_tick;
      tick && alt && pcs == 2'h0;
   endsequence
   sequence s_half_rate;
      !tick ##1 tick;
   endsequence
   // Last pixel of the last line: next fetch starts a frame
   sequence s_frame_wrap;
      tick && pix_q == PIX_LAST && lin_q == LIN_LAST;
   endsequence

   AST_LAND_WORD: assert property (
      s_frame_wrap ##0 !portrait |=>
         addr_q == {$past(start_raw[15:0]), 1'b0})
      else $error("landscape start not word scaled");
   AST_ALT_BYTE: assert property (
      s_frame_wrap ##0 alt |=> addr_q == $past(start_raw))
      else $error("alternate start not byte offset");
   AST_DEF_TWO_LINE: assert property (
      s_frame_wrap ##0 portrait && !alt |=>
         (addr_q & $past(stride_ext)) == 17'h00000 &&
         (addr_q | $past(stride_ext)) ==
         ($past(start_raw) | $past(stride_ext)))
      else $error("default scroll not two-line");
   AST_COL_STEP: assert property (
      tick && portrait && pix_q != PIX_LAST |=>
         addr_q == $past(addr_q) + $past(stride_ext))
      else $error("portrait pixel step not stride");
   AST_LINE_BACK: assert property (
      tick && portrait && pix_q == PIX_LAST && lin_q != LIN_LAST |=>
         addr_q == $past(base_q) - 17'h00001 && pix_q == '0)
      else $error("portrait line not next column");
   AST_BOOST_IDLE: assert property (
      portrait && !(boost && host_access_i) |-> !mclk_fast_o)
      else $error("memory clock fast without access");
   AST_NO_SPLIT: assert property (
      portrait |-> !screen2_en_o)
      else $error("second screen in portrait");
   AST_ALT_HALF: assert property (
      s_alt_tick ##0 $stable(ctrl_q)[*1] |=> s_half_rate)
      else $error("alternate pixel clock not halved");
   AST_PCS_DIV: assert property (
      portrait && !alt |-> div_if.div_sel == DIV_SEL_W'(pcs))
      else $error("pixel divisor not from select");
   AST_LAND_IGNORE: assert property (
      !portrait ##1 !portrait && $changed(stride_q) && tick &&
         pix_q != PIX_LAST |=> addr_q == $past(addr_q) + 17'h00001)
      else $error("landscape uses stride");
endmodule // prr_rotate
`default_nettype wire

//--- verif/prr_panel_model.sv
`timescale 1ns/100ps
`default_nettype none
module prr_panel_model
   import prr_pkg::*;
#(
   parameter int unsigned PANEL_W = 4,
   parameter int unsigned PANEL_H = 3
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [ADDR_W-1:0] fetch_addr_i,
   input wire logic fetch_stb_i,
   output logic [ADDR_W-1:0] frame_o [PANEL_W*PANEL_H],
   output int frame_cnt_o,
   output int gap_o
);
   localparam int N = PANEL_W * PANEL_H;
   logic [ADDR_W-1:0] cur_q [N];
   int pix_q;
   int run_q;
   // Panel takes one pixel per strobe, lines of PANEL_W
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pix_q <= 0;
         run_q <= 0;
         gap_o <= 0;
         frame_cnt_o <= 0;
      end else begin
         run_q <= fetch_stb_i ? 1 : run_q + 1;
         if (fetch_stb_i) begin
            gap_o <= run_q;
            cur_q[pix_q] <= fetch_addr_i;
            pix_q <= (pix_q == N - 1) ? 0 : pix_q + 1;
            if (pix_q == N - 1) begin
               for (int i = 0; i < N - 1; i++) frame_o[i] <= cur_q[i];
               frame_o[N-1] <= fetch_addr_i;
               frame_cnt_o <= frame_cnt_o + 1;
            end
         end
      end
   end
endmodule // prr_panel_model
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import prr_pkg::*;
   localparam int PW = 4;
   localparam int PH = 3;
   logic clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic host_access_i = 1'b0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, mclk_fast_o, screen2_en_o, fetch_stb_o;
   logic [ADDR_W-1:0] fetch_addr_o;
   logic [ADDR_W-1:0] frame [PW*PH];
   int frame_cnt;
   int gap;
   int n_errors = 0;
   int comparisons = 0;
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   prr_rotate #(.PANEL_W(PW), .PANEL_H(PH)) prr_rotate_inst (.clk_i(clk_i),
      .rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .host_access_i(host_access_i), .mclk_fast_o(mclk_fast_o),
      .screen2_en_o(screen2_en_o), .fetch_addr_o(fetch_addr_o),
      .fetch_stb_o(fetch_stb_o));
   prr_panel_model #(.PANEL_W(PW), .PANEL_H(PH)) prr_panel_model_inst (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .fetch_addr_i(fetch_addr_o),
      .fetch_stb_i(fetch_stb_o), .frame_o(frame), .frame_cnt_o(frame_cnt),
      .gap_o(gap));
   task automatic conclude();
      if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic apb(input logic [5:0] idx, input logic w, logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
      int k;
      @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= {idx, 2'b00};
      pwdata_i <= {24'h0, wd};
      @(posedge clk_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_errors++;
         conclude();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] d);
      logic [31:0] r;
      logic e;
      apb(idx, 1'b1, d, r, e);
   endtask
   task automatic rdc(input logic [5:0] idx, logic [7:0] x, logic xe);
      logic [31:0] r;
      logic e;
      apb(idx, 1'b0, 8'h00, r, e);
      chk("prdata", {24'h0, x}, r);
      chk("pslverr", {31'h0, xe}, {31'h0, e});
   endtask
   task automatic pins(input logic host, logic mclk, logic scr2);
      @(posedge clk_i);
      host_access_i <= host;
      @(negedge clk_i);
      chk("mclk_fast", {31'h0, mclk}, {31'h0, mclk_fast_o});
      chk("screen2", {31'h0, scr2}, {31'h0, screen2_en_o});
   endtask
   // Waits for a whole frame fetched under the latest settings
   task automatic frm(input logic [16:0] b, logic [16:0] st, logic [16:0] ls,
                      input int g);
      int f0;
      int k;
      logic [16:0] e;
      // Skip the write edge so a frame started there is not counted
      @(posedge clk_i);
      f0 = frame_cnt;
      k = 0;
      while (frame_cnt < f0 + 2 && k < 2000) begin
         @(posedge clk_i);
         k++;
      end
      if (k >= 2000) begin
         n_errors++;
         conclude();
      end
      @(negedge clk_i);
      for (int l = 0; l < PH; l++) begin
         for (int p = 0; p < PW; p++) begin
            e = b + 17'(l) * ls + 17'(p) * st;
            chk("pixel addr", {15'h0, e}, {15'h0, frame[l*PW+p]});
         end
      end
      chk("strobe gap", 32'(g), 32'(gap));
   endtask
   task automatic s_regs();
      pins(1'b1, 1'b1, 1'b1);
      rdc(IDX_START_LO, RST_START_LO, 1'b0);
      rdc(IDX_START_MID, RST_START_MID, 1'b0);
      rdc(IDX_START_TOP, RST_START_TOP, 1'b0);
      rdc(IDX_ROT_CTRL, RST_ROT_CTRL, 1'b0);
      rdc(IDX_STRIDE, RST_STRIDE, 1'b0);
      rdc(6'h3F, 8'h00, 1'b1);
      wr(IDX_ROT_CTRL, 8'h7F);
      rdc(IDX_ROT_CTRL, 8'h7F & CTL_WMASK, 1'b0);
      wr(IDX_START_TOP, 8'hFE);
      rdc(IDX_START_TOP, 8'hFE & TOP_WMASK, 1'b0);
   endtask
   task automatic s_land();
      wr(IDX_START_LO, 8'h21);
      wr(IDX_START_MID, 8'h43);
      wr(IDX_STRIDE, 8'h09);
      frm(17'h08642, 17'h1, 17'(PW), 1);
      pins(1'b0, 1'b1, 1'b1);
   endtask
   task automatic s_dflt();
      wr(IDX_STRIDE, 8'h04);
      wr(IDX_START_LO, 8'h06);
      wr(IDX_START_MID, 8'h00);
      wr(IDX_ROT_CTRL, 8'h81);
      frm(17'h00002, 17'h4, 17'h1FFFF, 2);
      pins(1'b1, 1'b0, 1'b0);
   endtask
   task automatic s_alt();
      wr(IDX_STRIDE, 8'h03);
      wr(IDX_START_LO, 8'h02);
      wr(IDX_START_TOP, 8'h01);
      wr(IDX_ROT_CTRL, 8'hC4);
      frm(17'h10002, 17'h3, 17'h1FFFF, 2);
      wr(IDX_START_LO, 8'h03);
      frm(17'h10003, 17'h3, 17'h1FFFF, 2);
      pins(1'b0, 1'b0, 1'b0);
      pins(1'b1, 1'b1, 1'b0);
   endtask
   initial begin
      repeat (20) @(posedge clk_i);
      rst_b_i <= 1'b1;
      s_regs();
      s_land();
      s_dflt();
      s_alt();
      conclude();
   end
endmodule // tb_top
`default_nettype wire
